// file: hdl/ts_defs.svh
// Timing, address and filter constants for the two-wire sensor link
`ifndef TS_DEFS_SVH
`define TS_DEFS_SVH
`define TS_SYS_PERIOD_NS 10
`define TS_SCL_PERIOD_NS 2500
`define TS_QTR_CYC       ((`TS_SCL_PERIOD_NS) / (4 * (`TS_SYS_PERIOD_NS)))
`define TS_FILT_CYC      3
// Device type identifier: arbitrary neutral value
`define TS_ADDR_TYPE     4'h6
`define TS_BYTE_BITS     4'h8
`endif

// file: hdl/ts_pkg.sv
// Types for the two ends of the two-wire sensor link: device states, host states and host commands
package ts_pkg;
   typedef enum logic [2:0] {TS_D_IDLE, TS_D_ADDR, TS_D_AACK, TS_D_WRX, TS_D_WACK, TS_D_RTX, TS_D_RACK} ts_dst_e;
   typedef enum logic [1:0] {TS_H_IDLE, TS_H_START, TS_H_STOP, TS_H_BYTE} ts_hst_e;
   typedef enum logic [1:0] {TS_CMD_START, TS_CMD_STOP, TS_CMD_WRITE, TS_CMD_READ} ts_cmd_e;
endpackage

// file: hdl/ts_link_if.sv
// Open-drain two-wire link between bus master and sensor slave
`timescale 1ns/100ps
`default_nettype none
interface ts_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Pull-ups: a line is low only while some end drives a zero
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
   modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// file: hdl/ts_dev.sv
// Slave end of the two-wire sensor link: framing, address match, ack
`timescale 1ns/100ps
`default_nettype none
`include "ts_defs.svh"
module ts_dev
   import ts_pkg::*;
#(
   parameter logic [3:0] TYPE_ID  = `TS_ADDR_TYPE,
   parameter int         FILT_CYC = `TS_FILT_CYC
) (
   input  wire logic       clk_sys_i,             // System clock
   input  wire logic       resetn_i,              // Async reset, active low
   ts_link_if.dev          link,                  // Two-wire link
   input  wire logic [2:0] address_strap_pins_i,  // Low address bits straps
   input  wire logic [7:0] tx_byte_i,             // Next byte to send on reads
   input  wire logic       wr_reject_i,           // Refuse written bytes
   output logic      [7:0] rx_byte_o,             // Last byte received
   output logic            rx_valid_o,            // Pulse: rx_byte_o new
   output logic            tx_load_o,             // Pulse: tx_byte_i taken
   output logic            selected_o,            // Addressed in a transfer
   output logic            read_o,                // Direction of transfer
   output logic            bus_idle_o             // Both lines high
);
   typedef struct packed {
      logic       scl_m;
      logic       scl_s;
      logic       sda_m;
      logic       sda_s;
      logic [2:0] strap_m;
      logic [2:0] strap_s;
      logic       scl_f;
      logic       sda_f;
      logic [3:0] scl_c;
      logic [3:0] sda_c;
      ts_dst_e    st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic       mack;
      logic       sda_oe;
      logic [7:0] rx_byte;
      logic       rx_valid;
      logic       tx_load;
      logic       sel;
      logic       rd;
      logic       idle;
   } ts_dev_s;

   ts_dev_s s;
   ts_dev_s next_s;
   logic    scl_rise;
   logic    scl_fall;
   logic    start_seen;
   logic    stop_seen;

   // Returns {filtered level, counter}; a level must persist FILT_CYC cycles
   function automatic logic [4:0] filt(input logic in, input logic f, input logic [3:0] c);
      logic [3:0] nc;
      nc = 4'h0;
      if (in == f) begin
         return {f, 4'h0};
      end
      nc = c + 4'h1;
      if (nc >= 4'(FILT_CYC)) begin
         return {in, 4'h0};
      end
      return {f, nc};
   endfunction

   always_comb begin
      next_s = s;
      next_s.rx_valid = 1'b0;
      next_s.tx_load = 1'b0;
      next_s.scl_m = link.scl;
      next_s.scl_s = s.scl_m;
      next_s.sda_m = link.sda;
      next_s.sda_s = s.sda_m;
      next_s.strap_m = address_strap_pins_i;
      next_s.strap_s = s.strap_m;
      {next_s.scl_f, next_s.scl_c} = filt(s.scl_s, s.scl_f, s.scl_c);
      {next_s.sda_f, next_s.sda_c} = filt(s.sda_s, s.sda_f, s.sda_c);
      scl_rise = next_s.scl_f & ~s.scl_f;
      scl_fall = ~next_s.scl_f & s.scl_f;
      start_seen = s.scl_f & next_s.scl_f & s.sda_f & ~next_s.sda_f;
      stop_seen = s.scl_f & next_s.scl_f & ~s.sda_f & next_s.sda_f;
      next_s.idle = next_s.scl_f & next_s.sda_f;
      if (start_seen) begin
         // Works from any state, so a repeated start restarts framing
         next_s.st = TS_D_ADDR;
         next_s.cnt = 4'h0;
         next_s.sda_oe = 1'b0;
         next_s.sel = 1'b0;
      end else if (stop_seen) begin
         next_s.st = TS_D_IDLE;
         next_s.sda_oe = 1'b0;
         next_s.sel = 1'b0;
      end else begin
         case (s.st)
            TS_D_IDLE: begin
               next_s.sda_oe = 1'b0;
            end
            TS_D_ADDR, TS_D_WRX: begin
               if (scl_rise) begin
                  next_s.sh = {s.sh[6:0], next_s.sda_f};
                  next_s.cnt = s.cnt + 4'h1;
               end else if (scl_fall && s.cnt == `TS_BYTE_BITS) begin
                  if (s.st == TS_D_ADDR) begin
                     if (s.sh[7:1] == {TYPE_ID, s.strap_s}) begin
                        next_s.sda_oe = 1'b1;
                        next_s.st = TS_D_AACK;
                        next_s.sel = 1'b1;
                        next_s.rd = s.sh[0];
                     end else begin
                        next_s.st = TS_D_IDLE;
                     end
                  end else begin
                     next_s.rx_byte = s.sh;
                     next_s.rx_valid = 1'b1;
                     next_s.sda_oe = ~wr_reject_i;
                     next_s.st = TS_D_WACK;
                  end
               end
            end
            TS_D_AACK: begin
               if (scl_fall) begin
                  next_s.cnt = 4'h0;
                  if (s.rd) begin
                     next_s.sh = tx_byte_i;
                     next_s.tx_load = 1'b1;
                     next_s.sda_oe = ~tx_byte_i[7];
                     next_s.st = TS_D_RTX;
                  end else begin
                     next_s.sda_oe = 1'b0;
                     next_s.st = TS_D_WRX;
                  end
               end
            end
            TS_D_WACK: begin
               // No byte limit: every byte loops back for another
               if (scl_fall) begin
                  next_s.sda_oe = 1'b0;
                  next_s.cnt = 4'h0;
                  next_s.st = TS_D_WRX;
               end
            end
            TS_D_RTX: begin
               if (scl_rise) begin
                  next_s.cnt = s.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s.cnt == `TS_BYTE_BITS) begin
                     next_s.sda_oe = 1'b0;
                     next_s.st = TS_D_RACK;
                  end else begin
                     next_s.sh = {s.sh[6:0], 1'b0};
                     next_s.sda_oe = ~s.sh[6];
                  end
               end
            end
            TS_D_RACK: begin
               if (scl_rise) begin
                  next_s.mack = ~next_s.sda_f;
               end else if (scl_fall) begin
                  next_s.cnt = 4'h0;
                  if (s.mack) begin
                     next_s.sh = tx_byte_i;
                     next_s.tx_load = 1'b1;
                     next_s.sda_oe = ~tx_byte_i[7];
                     next_s.st = TS_D_RTX;
                  end else begin
                     // Line stays released so the master can stop
                     next_s.st = TS_D_IDLE;
                     next_s.sel = 1'b0;
                  end
               end
            end
            default: begin
               next_s.st = TS_D_IDLE;
               next_s.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '{scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1, scl_f: 1'b1, sda_f: 1'b1,
                st: TS_D_IDLE, idle: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = s.sda_oe;
   assign rx_byte_o = s.rx_byte;
   assign rx_valid_o = s.rx_valid;
   assign tx_load_o = s.tx_load;
   assign selected_o = s.sel;
   assign read_o = s.rd;
   assign bus_idle_o = s.idle;
endmodule
`default_nettype wire

// file: hdl/ts_host.sv
// Master end of the two-wire sensor link: clock divider and bit sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ts_defs.svh"
module ts_host
   import ts_pkg::*;
#(
   parameter int QTR_CYC = `TS_QTR_CYC
) (
   input  wire logic       clk_sys_i,    // System clock
   input  wire logic       resetn_i,     // Async reset, active low
   ts_link_if.host         link,         // Two-wire link
   input  wire logic       cmd_valid_i,  // Command offered
   input  wire ts_cmd_e    cmd_i,        // Start, stop, write or read
   input  wire logic [7:0] wdata_i,      // Byte to write
   input  wire logic       rd_last_i,    // Read: answer no-ack
   output logic            cmd_ready_o,  // Idle, command taken
   output logic            done_o,       // Pulse: command finished
   output logic      [7:0] rdata_o,      // Byte read
   output logic            ack_o         // Write: slave acked
);
   typedef struct packed {
      logic       sda_m;
      logic       sda_s;
      logic       scl_oe;
      logic       sda_oe;
      logic [11:0] div;
      logic [1:0] ph;
      logic [3:0] bitn;
      ts_hst_e    st;
      logic [7:0] sh;
      logic       rd;
      logic       last;
      logic [7:0] rdata;
      logic       ack;
      logic       done;
      logic       ready;
   } ts_host_s;

   ts_host_s s;
   ts_host_s next_s;
   logic     tick;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.sda_m = link.sda;
      next_s.sda_s = s.sda_m;
      tick = (s.div == 12'(QTR_CYC - 1));
      next_s.div = tick ? 12'h0 : s.div + 12'h1;
      if (s.st != TS_H_IDLE && tick) begin
         next_s.ph = s.ph + 2'h1;
      end
      case (s.st)
         TS_H_IDLE: begin
            if (cmd_valid_i) begin
               next_s.ready = 1'b0;
               next_s.ph = 2'h0;
               next_s.div = 12'h0;
               next_s.bitn = 4'h0;
               next_s.sh = wdata_i;
               next_s.rd = (cmd_i == TS_CMD_READ);
               next_s.last = rd_last_i;
               case (cmd_i)
                  TS_CMD_START: next_s.st = TS_H_START;
                  TS_CMD_STOP: next_s.st = TS_H_STOP;
                  default: next_s.st = TS_H_BYTE;
               endcase
            end
         end
         TS_H_START: begin
            if (tick) begin
               case (s.ph)
                  2'h0: next_s.sda_oe = 1'b0;
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: next_s.sda_oe = 1'b1;
                  default: begin
                     next_s.scl_oe = 1'b1;
                     next_s.st = TS_H_IDLE;
                     next_s.done = 1'b1;
                     next_s.ready = 1'b1;
                  end
               endcase
            end
         end
         TS_H_STOP: begin
            if (tick) begin
               case (s.ph)
                  2'h0: next_s.sda_oe = 1'b1;
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: next_s.sda_oe = 1'b0;
                  default: begin
                     next_s.st = TS_H_IDLE;
                     next_s.done = 1'b1;
                     next_s.ready = 1'b1;
                  end
               endcase
            end
         end
         TS_H_BYTE: begin
            if (tick) begin
               case (s.ph)
                  2'h0: begin
                     // Data is set up only while the clock is low
                     if (s.bitn == `TS_BYTE_BITS) begin
                        next_s.sda_oe = s.rd & ~s.last;
                     end else begin
                        next_s.sda_oe = ~s.rd & ~s.sh[7];
                     end
                  end
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: begin
                     if (s.bitn == `TS_BYTE_BITS) begin
                        next_s.ack = ~s.sda_s;
                     end else begin
                        next_s.sh = {s.sh[6:0], s.sda_s};
                     end
                  end
                  default: begin
                     next_s.scl_oe = 1'b1;
                     next_s.bitn = s.bitn + 4'h1;
                     if (s.bitn == `TS_BYTE_BITS) begin
                        next_s.rdata = s.sh;
                        next_s.st = TS_H_IDLE;
                        next_s.done = 1'b1;
                        next_s.ready = 1'b1;
                     end
                  end
               endcase
            end
         end
         default: next_s.st = TS_H_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '{sda_m: 1'b1, sda_s: 1'b1, st: TS_H_IDLE, ready: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = s.scl_oe;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = s.sda_oe;
   assign cmd_ready_o = s.ready;
   assign done_o = s.done;
   assign rdata_o = s.rdata;
   assign ack_o = s.ack;
endmodule
`default_nettype wire

// file: tb/ts_link_properties.sv
// Concurrent checks on the two-wire link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module ts_link_properties #(
   parameter int QTR = 12
) (
   input wire logic clk_sys_i,    // System clock
   input wire logic resetn_i,     // Async reset, active low
   input wire logic host_scl_oe,  // Host pulls clock low
   input wire logic host_sda_oe,  // Host pulls data low
   input wire logic dev_sda_oe,   // Device pulls data low
   input wire logic scl,          // Resolved clock line
   input wire logic sda           // Resolved data line
);
   localparam int W = 4 * QTR;
   logic      p_scl;
   logic      p_sda;
   logic      in_xfer;
   wire logic start_ev = p_scl & scl & p_sda & ~sda;
   wire logic stop_ev  = p_scl & scl & ~p_sda & sda;
   // Raw line edges: the device filters, so these lead its own view
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         p_scl   <= 1'b1;
         p_sda   <= 1'b1;
         in_xfer <= 1'b0;
      end else begin
         p_scl   <= scl;
         p_sda   <= sda;
         in_xfer <= start_ev | (in_xfer & ~stop_ev);
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   sequence hi_phase;
      ##[1:W] $rose(scl) ##1 scl [*8];
   endsequence
   sequence low_phase;
      !scl [*8];
   endsequence
   dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device data changed while clock high");
   dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data not steady in clock high");
   dev_frame_a: assert property (dev_sda_oe |-> in_xfer)
      else $error("device drove data outside a transfer");
   ack_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout hi_phase)
      else $error("device low bit not held through clock high");
   scl_low_a: assert property ($fell(scl) |-> low_phase)
      else $error("clock low phase too short");
   host_sda_a: assert property ($changed(host_sda_oe) && scl |-> $past(scl, 8))
      else $error("host data moved next to a clock edge");
   host_release_a: assert property (dev_sda_oe && scl |-> !host_sda_oe)
      else $error("host drove data while device drives");
   stop_idle_a: assert property (stop_ev |-> ##1 (scl && sda) [*8])
      else $error("lines not idle after stop");
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench joining host and device ends of the two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "ts_defs.svh"
module tb;
   import ts_pkg::*;
   localparam int          QTR  = 12;
   localparam logic [10:0] NONE = 11'h000;
   localparam logic [10:0] ACK  = 11'h600;
   localparam logic [10:0] NAK  = 11'h400;
   logic        clk_sys_i   = 1'b0;
   logic        resetn_i    = 1'b0;
   logic        cmd_valid_i = 1'b0;
   ts_cmd_e     cmd_i       = TS_CMD_START;
   logic [7:0]  wdata_i     = 8'h00;
   logic        rd_last_i   = 1'b0;
   logic [2:0]  strap       = 3'h0;
   logic [7:0]  tx_byte_i   = 8'h00;
   logic        wr_reject_i = 1'b0;
   logic [31:0] seed        = 32'hffe4;
   logic        cmd_ready_o, done_o, ack_o, rx_valid_o, tx_load_o, selected_o, read_o, bus_idle_o;
   logic [7:0]  rdata_o, rx_byte_o, addr, d;
   logic [10:0] e;
   logic [10:0] expq[$];
   logic [7:0]  rxq[$];
   int          error_cnt   = 0;
   int          check_count = 0;
   int          tx_cnt      = 0;

   ts_link_if link();
   ts_host #(.QTR_CYC(QTR)) u_ts_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .rd_last_i(rd_last_i),
      .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o), .ack_o(ack_o));
   ts_dev u_ts_dev (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link),
      .address_strap_pins_i(strap), .tx_byte_i(tx_byte_i), .wr_reject_i(wr_reject_i),
      .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .tx_load_o(tx_load_o),
      .selected_o(selected_o), .read_o(read_o), .bus_idle_o(bus_idle_o));
   ts_link_properties #(.QTR(QTR)) u_ts_link_properties (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
      .scl(link.scl), .sda(link.sda));

   always #5 clk_sys_i = ~clk_sys_i;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Entered at a falling edge; ready is high then, so the next rise takes it
   task automatic send(input ts_cmd_e c, input logic [7:0] dt, input logic l, input logic [10:0] ex);
      int n;
      n = 0;
      cmd_valid_i = 1'b1;
      cmd_i = c;
      wdata_i = dt;
      rd_last_i = l;
      expq.push_back(ex);
      @(negedge clk_sys_i);
      cmd_valid_i = 1'b0;
      while (done_o !== 1'b1 && n < 2000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 2000) begin
         error_cnt++;
         stop_test();
      end
   endtask

   // Pulses stand one cycle; the falling edge sees each pulse once
   always @(negedge clk_sys_i) begin
      if (done_o === 1'b1 && expq.size() > 0) begin
         e = expq.pop_front();
         chk("ready", {7'h00, cmd_ready_o}, 8'h01);
         if (e[10])
            chk("ack", {7'h00, ack_o}, {7'h00, e[9]});
         if (e[8])
            chk("rdata", rdata_o, e[7:0]);
      end
      if (rx_valid_o === 1'b1) begin
         if (rxq.size() == 0)
            chk("rx_extra", 8'h01, 8'h00);
         else
            chk("rx_byte", rx_byte_o, rxq.pop_front());
      end
      if (tx_load_o === 1'b1)
         tx_cnt++;
   end

   initial begin
      repeat (16) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      d = 8'(xs());
      strap = d[2:0];
      chk("idle", {7'h00, bus_idle_o}, 8'h01);
      addr = {`TS_ADDR_TYPE, strap, 1'b0};
      send(TS_CMD_START, 8'h00, 1'b0, NONE);
      chk("busy", {7'h00, bus_idle_o}, 8'h00);
      send(TS_CMD_WRITE, addr, 1'b0, ACK);
      chk("sel", {7'h00, selected_o}, 8'h01);
      chk("dir_wr", {7'h00, read_o}, 8'h00);
      // Last byte of the burst is refused by the receiver
      for (int i = 0; i < 3; i++) begin
         d = 8'(xs());
         wr_reject_i = (i == 2);
         rxq.push_back(d);
         send(TS_CMD_WRITE, d, 1'b0, (i == 2) ? NAK : ACK);
      end
      wr_reject_i = 1'b0;
      send(TS_CMD_STOP, 8'h00, 1'b0, NONE);
      chk("sel_stop", {7'h00, selected_o}, 8'h00);
      chk("idle_stop", {7'h00, bus_idle_o}, 8'h01);
      $display("test write done");
      send(TS_CMD_START, 8'h00, 1'b0, NONE);
      send(TS_CMD_WRITE, addr | 8'h01, 1'b0, ACK);
      chk("dir_rd", {7'h00, read_o}, 8'h01);
      // Next byte is loaded a few cycles after the previous one completes
      for (int i = 0; i < 3; i++) begin
         d = 8'(xs());
         tx_byte_i = d;
         send(TS_CMD_READ, 8'h00, i == 2, {3'b001, d});
      end
      // The device sees the last clock fall through its filter, after done
      repeat (8) @(negedge clk_sys_i);
      chk("sel_no_acknowledge_high", {7'h00, selected_o}, 8'h00);
      send(TS_CMD_START, 8'h00, 1'b0, NONE);
      send(TS_CMD_WRITE, addr, 1'b0, ACK);
      chk("sel_rs", {7'h00, selected_o}, 8'h01);
      send(TS_CMD_STOP, 8'h00, 1'b0, NONE);
      $display("test read and repeated start done");
      send(TS_CMD_START, 8'h00, 1'b0, NONE);
      send(TS_CMD_WRITE, addr ^ 8'h02, 1'b0, NAK);
      chk("sel_miss", {7'h00, selected_o}, 8'h00);
      send(TS_CMD_WRITE, 8'(xs()), 1'b0, NAK);
      send(TS_CMD_STOP, 8'h00, 1'b0, NONE);
      chk("rx_left", 8'(rxq.size()), 8'h00);
      // One load after the address ack, one per master ack; none after no-ack
      chk("tx_loads", 8'(tx_cnt), 8'h03);
      $display("test address mismatch done");
      stop_test();
   end
endmodule
`default_nettype wire
